// file: core/pcg_pkg.sv
// Shared constants, state and field layout for the pixel clock deglitch block.
// Assumes a single 125 MHz core clock; every pin is synchronous to it.
package pcg_pkg;
  localparam int unsigned SHIFT_W = 34;
  localparam int unsigned DIV_W   = 10;
  localparam int unsigned SRC_LSB = 14;
  localparam int unsigned SRC_W   = 2;
  localparam int unsigned P_LSB   = 16;
  localparam int unsigned P_W     = 4;
  localparam int unsigned L_LSB   = 20;
  localparam int unsigned L_W     = 4;
  localparam int unsigned R_LSB   = 24;
  localparam int unsigned R_W     = 10;

  localparam logic [SRC_W-1:0] SRC_XTAL_HALF = 2'h0;
  localparam logic [SRC_W-1:0] SRC_INTERNAL  = 2'h1;
  localparam logic [SRC_W-1:0] SRC_PASSTHRU  = 2'h2;
  localparam logic [SRC_W-1:0] SRC_EXT_OSC   = 2'h3;

  localparam logic [SRC_W-1:0]   SRC_RESET    = 2'h0;
  localparam logic [P_W-1:0]     P_RESET      = 4'h3;
  localparam logic [L_W-1:0]     L_RESET      = 4'h3;
  localparam logic [R_W-1:0]     R_RESET      = 10'h014;
  localparam logic [SHIFT_W-1:0] SHADOW_RESET = 34'h0;
  localparam logic [5:0]         READ_LAST    = 6'h21;
  localparam logic [3:0]         FREEZE_EVENTS = 4'h8;

  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_FREEZE} pcg_state_e;

  typedef struct packed {
    logic [DIV_W-1:0] count;
  } pcg_div_s;

  typedef struct packed {
    pcg_state_e       state;
    logic [SHIFT_W-1:0] shadow;
    logic [5:0]       readPtr;
    logic [SRC_W-1:0] src;
    logic [P_W-1:0]   pdiv;
    logic [L_W-1:0]   ldiv;
    logic [R_W-1:0]   rdiv;
    logic [SRC_W-1:0] runSrc;
    logic [P_W-1:0]   runP;
    logic [3:0]       freezeCnt;
    logic             strobeNPrev;
    logic             refPrev;
    logic             extPrev;
    logic             pixelOut;
    logic             loadOut;
    logic             compareTick;
    logic             dataOut;
    logic             dataOeN;
  } pcg_top_s;
endpackage

// file: core/pcg_div_if.sv
// Carrier between the top block and one modulus divider.
// Assumes driver and divider share the core clock.
`timescale 1ns/1ps
interface pcg_div_if;
  logic                     advance;
  logic                     restart;
  logic [pcg_pkg::DIV_W-1:0] terminal;
  logic                     wrap;
  modport ctrl (output advance, output restart, output terminal, input wrap);
  modport div  (input advance, input restart, input terminal, output wrap);
endinterface

// file: core/pcg_divider.sv
// Modulus counter: wraps after terminal+1 advances, wrap is combinational.
// Advance may be a one-cycle strobe or held high to count every clock; a terminal lowered below the count wraps at the next
// advance, so a reload never runs the count the long way round.
`timescale 1ns/1ps
module pcg_divider (
  input  wire logic clock,
  input  wire logic rst,
  pcg_div_if.div    port
);
  pcg_pkg::pcg_div_s s_q;
  pcg_pkg::pcg_div_s s_d;

  assign port.wrap = port.advance && (s_q.count >= port.terminal);

  always_comb begin
    s_d = s_q;
    if (port.restart) begin
      s_d.count = '0;
    end else if (port.wrap) begin
      s_d.count = '0;
    end else if (port.advance) begin
      s_d.count = s_q.count + 10'h001;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// file: core/pcg_clock_core.sv
// Pixel clock source selection, deglitching, load clock and serial programming port.
// Assumes all pins synchronous to clock; the host keeps the strobe quiet between accesses.
//
// What this block does
// RULE1: [RULE1] A source or rate change never yields a pixel pulse shorter than the briefest programmed half period.
// RULE2: [RULE2] A transfer that alters the source select or pixel modulus bits starts the deglitch sequence by itself.
// RULE3: [RULE3] During deglitch the pixel output is held low and restarts several periods later on the new source.
// RULE4: [RULE4] The host keeps the serial strobe idle during accesses aimed elsewhere, as it clocks the port.
// RULE5: [RULE5] The port select may take any level while idle except in the cycle the strobe returns high; it is looked at only then and while the strobe is low.
// RULE6: [RULE6] With the load clock gate low, load clock pulses are suppressed.
// RULE7: [RULE7] The load clock is an integer submultiple of the pixel clock, stepping only on pixel rising edges.
// RULE8: [RULE8] The reference divider advances on falling edges of the reference input.
// RULE9: [RULE9] For genlock the host programs the reference modulus to one and keeps the sync present.
// RULE10: [RULE10] Source select codes route crystal half, internal divider, passthrough or external oscillator.
// RULE11: [RULE11] The pixel modulus field holds modulus minus one, giving moduli 1 to 16.
`timescale 1ns/1ps
module pcg_clock_core (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic serialStrobeN,
  input  wire logic portSelect,
  input  wire logic readWriteSelect,
  input  wire logic serialDataIn,
  output logic      serialDataOut,
  output logic      serialDataOeN,
  input  wire logic referenceInput,
  input  wire logic externalClockInput,
  input  wire logic loadClockGate,
  output logic      pixelClockOut,
  output logic      loadClockOut,
  output logic      compareTick
);
  pcg_pkg::pcg_top_s s_q;
  pcg_pkg::pcg_top_s s_d;
  logic              refFall;
  logic              extChange;
  logic              strobeRise;
  logic              srcEvent;
  logic              srcHigh;
  logic              cfgDiff;
  logic              pixRise;

  pcg_div_if pixDiv ();
  pcg_div_if loadDiv ();
  pcg_div_if refDiv ();

  pcg_divider u_pixDiv (.clock(clock), .rst(rst), .port(pixDiv));
  pcg_divider u_loadDiv (.clock(clock), .rst(rst), .port(loadDiv));
  pcg_divider u_refDiv (.clock(clock), .rst(rst), .port(refDiv));

  assign serialDataOut = s_q.dataOut;
  assign serialDataOeN = s_q.dataOeN;
  assign pixelClockOut = s_q.pixelOut;
  assign loadClockOut  = s_q.loadOut;
  assign compareTick   = s_q.compareTick;

  always_comb begin
    s_d        = s_q;
    refFall    = s_q.refPrev && !referenceInput;                       // [RULE8]
    extChange  = s_q.extPrev != externalClockInput;
    strobeRise = !s_q.strobeNPrev && serialStrobeN;                    // [RULE4]
    cfgDiff    = (s_q.src != s_q.runSrc) || (s_q.pdiv != s_q.runP);
    s_d.strobeNPrev = serialStrobeN;
    s_d.refPrev     = referenceInput;
    s_d.extPrev     = externalClockInput;

    // Reference divider sees only falling edges, so a sync source paces it
    refDiv.advance  = refFall;                                         // [RULE8]
    refDiv.restart  = 1'b0;
    refDiv.terminal = s_q.rdiv - 10'h001;
    s_d.compareTick = refDiv.wrap;

    pixDiv.advance  = 1'b1;
    pixDiv.restart  = 1'b0;
    pixDiv.terminal = {6'h00, s_q.runP};                               // [RULE11]

    // Serial port: select and direction matter while the strobe is low and in the cycle it returns high
    s_d.dataOeN = 1'b1;
    s_d.dataOut = 1'b0;
    if (!serialStrobeN && portSelect && readWriteSelect) begin         // [RULE5]
      s_d.dataOeN = 1'b0;
      s_d.dataOut = s_q.shadow[s_q.readPtr];
    end
    if (strobeRise) begin                                              // [RULE5]
      if (portSelect && readWriteSelect) begin
        s_d.readPtr = (s_q.readPtr == pcg_pkg::READ_LAST) ? 6'h00 : s_q.readPtr + 6'h01;
      end else if (portSelect) begin
        s_d.shadow = {serialDataIn, s_q.shadow[pcg_pkg::SHIFT_W-1:1]};
      end else begin
        s_d.src     = s_q.shadow[pcg_pkg::SRC_LSB +: pcg_pkg::SRC_W];
        s_d.pdiv    = s_q.shadow[pcg_pkg::P_LSB +: pcg_pkg::P_W];
        s_d.ldiv    = s_q.shadow[pcg_pkg::L_LSB +: pcg_pkg::L_W];
        s_d.rdiv    = s_q.shadow[pcg_pkg::R_LSB +: pcg_pkg::R_W];
        s_d.readPtr = 6'h00;
      end
    end

    // In ST_RUN with no pending change, each source event flips the pixel output
    case (s_q.runSrc)                                                  // [RULE10]
      pcg_pkg::SRC_XTAL_HALF: srcEvent = refFall;
      pcg_pkg::SRC_INTERNAL:  srcEvent = pixDiv.wrap;
      default:                srcEvent = extChange;
    endcase
    srcHigh = ((s_q.runSrc == pcg_pkg::SRC_PASSTHRU) || (s_q.runSrc == pcg_pkg::SRC_EXT_OSC))
              ? externalClockInput : 1'b1;

    case (s_q.state)
      pcg_pkg::ST_RUN: begin
        if (cfgDiff) begin
          s_d.state = pcg_pkg::ST_WAIT;                                // [RULE2]
        end else if (srcEvent) begin
          s_d.pixelOut = !s_q.pixelOut;                                // [RULE10]
        end
      end
      pcg_pkg::ST_WAIT: begin
        // Freeze only at a low level so the running high phase is never cut
        if (srcEvent) begin
          s_d.pixelOut = 1'b0;                                         // [RULE1]
        end
        if (!s_q.pixelOut || srcEvent) begin
          s_d.state     = pcg_pkg::ST_FREEZE;
          s_d.runSrc    = s_q.src;
          s_d.runP      = s_q.pdiv;
          s_d.freezeCnt = 4'h0;
          pixDiv.restart = 1'b1;
        end
      end
      pcg_pkg::ST_FREEZE: begin
        s_d.pixelOut = 1'b0;                                           // [RULE3]
        if (srcEvent) begin
          if (s_q.freezeCnt >= pcg_pkg::FREEZE_EVENTS && srcHigh) begin
            s_d.state    = pcg_pkg::ST_RUN;                            // [RULE3]
            s_d.pixelOut = 1'b1;
          end else if (s_q.freezeCnt < pcg_pkg::FREEZE_EVENTS) begin
            s_d.freezeCnt = s_q.freezeCnt + 4'h1;
          end
        end
      end
      default: begin
        s_d.state = pcg_pkg::ST_RUN;
      end
    endcase

    // Load clock steps on pixel rising edges; the gate only blocks a rise
    pixRise          = !s_q.pixelOut && s_d.pixelOut;
    loadDiv.advance  = pixRise;                                        // [RULE7]
    loadDiv.restart  = 1'b0;
    loadDiv.terminal = {6'h00, s_q.ldiv};
    if (loadDiv.wrap && (s_q.loadOut || loadClockGate)) begin          // [RULE6]
      s_d.loadOut = !s_q.loadOut;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q             <= '0;
      s_q.state       <= pcg_pkg::ST_RUN;
      s_q.shadow      <= pcg_pkg::SHADOW_RESET;
      s_q.src         <= pcg_pkg::SRC_RESET;
      s_q.pdiv        <= pcg_pkg::P_RESET;
      s_q.ldiv        <= pcg_pkg::L_RESET;
      s_q.rdiv        <= pcg_pkg::R_RESET;
      s_q.runSrc      <= pcg_pkg::SRC_RESET;
      s_q.runP        <= pcg_pkg::P_RESET;
      s_q.strobeNPrev <= 1'b1;
      s_q.dataOeN     <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Cycles since the pixel output last changed, saturating
  logic [7:0] stab_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stab_q <= 8'h00;
    end else if (s_d.pixelOut != s_q.pixelOut) begin
      stab_q <= 8'h00;
    end else if (stab_q != 8'hff) begin
      stab_q <= stab_q + 8'h01;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence sWaitThenFreeze;
    s_q.state == pcg_pkg::ST_WAIT ##1 s_q.state == pcg_pkg::ST_FREEZE;
  endsequence

  a_short_pulse_guard: assert property ( // [RULE1]
    ($changed(s_q.pixelOut) && s_q.runSrc == pcg_pkg::SRC_INTERNAL
      && $past(s_q.runSrc) == pcg_pkg::SRC_INTERNAL && $past(s_q.runP) == s_q.runP)
      |-> $past(stab_q) >= {4'h0, s_q.runP})
    else $error("pixel pulse shorter than programmed half period");
  a_change_starts_deglitch: assert property ( // [RULE2]
    (s_q.state == pcg_pkg::ST_RUN && cfgDiff) |=> s_q.state == pcg_pkg::ST_WAIT)
    else $error("config change did not start deglitch");
  a_freeze_holds_low: assert property ( // [RULE3]
    sWaitThenFreeze |-> !s_q.pixelOut ##1 (!s_q.pixelOut throughout
      (s_q.state == pcg_pkg::ST_FREEZE)[*8]))
    else $error("pixel output moved while frozen");
  a_gate_blocks_load: assert property ( // [RULE6]
    $rose(s_q.loadOut) |-> $past(loadClockGate))
    else $error("load clock rose while gated off");
  a_load_on_pixel: assert property ( // [RULE7]
    $changed(s_q.loadOut) |-> $rose(s_q.pixelOut))
    else $error("load clock stepped off a pixel rise");
  a_ref_falling_edge: assert property ( // [RULE8]
    s_q.compareTick |-> !$past(referenceInput) && $past(referenceInput, 2))
    else $error("reference divider advanced off a falling edge");
  a_xtal_half_route: assert property ( // [RULE10]
    (s_q.state == pcg_pkg::ST_RUN && !cfgDiff && s_q.runSrc == pcg_pkg::SRC_XTAL_HALF
      && refFall) |=> $changed(s_q.pixelOut))
    else $error("crystal half mode missed a reference fall");
  a_pixel_modulus: assert property ( // [RULE11]
    ($changed(s_q.pixelOut) && s_q.state == pcg_pkg::ST_RUN
      && $past(s_q.state) == pcg_pkg::ST_RUN && s_q.runSrc == pcg_pkg::SRC_INTERNAL
      && $past(stab_q) != 8'hff)
      |-> $past(stab_q) == {4'h0, s_q.runP})
    else $error("pixel half period differs from modulus");
endmodule

// file: bench/pcg_host_model.sv
// Host controller model driving the serial programming port.
// Assumes tasks are called from the bench; drives just after rising edges.
`timescale 1ns/1ps
module pcg_host_model (
  input  wire logic clock,
  output logic      strobeN,
  output logic      sel,
  output logic      rw,
  output logic      dataIn,
  input  wire logic dataOut,
  input  wire logic dataOeN
);
  int seed = 32'h39da;
  initial begin
    strobeN = 1'b1;
    sel = 1'b0;
    rw = 1'b0;
    dataIn = 1'b0;
  end
  // Strobe held low for lowCycles edges; select may wander only while idle
  task automatic strobe(input logic s, input logic r, input logic d, input int lowCycles,
                        output logic [1:0] seen);
    @(posedge clock);
    #1;
    strobeN = 1'b0;
    sel = s;
    rw = r;
    dataIn = d;
    repeat (lowCycles) begin
      @(posedge clock);
      #1;
    end
    seen = {dataOeN, dataOut};
    strobeN = 1'b1;
    @(posedge clock);
    #1;
    sel = 1'($random(seed));
    rw = 1'($random(seed));
    dataIn = 1'($random(seed));
  endtask
  task automatic write_word(input logic [33:0] w);
    logic [1:0] seen;
    for (int i = 0; i < 34; i++) begin
      strobe(1'b1, 1'b0, w[i], 1, seen);
    end
    strobe(1'b0, 1'($random(seed)), 1'($random(seed)), 1, seen);
  endtask
endmodule

// file: bench/testbench.sv
// Self-checking bench for the pixel clock deglitch block.
// Assumes a 125 MHz clock; reference runs at 1/16 and external clock at 1/6 of it.
`timescale 1ns/1ps
module testbench;
  logic clock, rst, refIn, extIn, gate, pixPrev;
  logic strobeN, sel, rw, dIn, dOut, oeN, pixel, load, tick;
  int seed = 32'h39da;
  int num_errors = 0;
  int num_checks = 0;
  int cycles = 0, runLen = 0, minRun = 1, maxRun = 0;
  pcg_clock_core dut (.clock(clock), .rst(rst), .serialStrobeN(strobeN), .portSelect(sel),
    .readWriteSelect(rw), .serialDataIn(dIn), .serialDataOut(dOut), .serialDataOeN(oeN),
    .referenceInput(refIn), .externalClockInput(extIn), .loadClockGate(gate),
    .pixelClockOut(pixel), .loadClockOut(load), .compareTick(tick));
  pcg_host_model host (.clock(clock), .strobeN(strobeN), .sel(sel), .rw(rw), .dataIn(dIn),
    .dataOut(dOut), .dataOeN(oeN));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always begin
    repeat (8) @(posedge clock);
    #1 refIn = ~refIn;
  end
  always begin
    repeat (3) @(posedge clock);
    #1 extIn = ~extIn;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Hang guard: well above the longest measurement chain
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      final_report();
    end
  end
  // Pulse width watch across every source change
  // Falling edge, so the level launched at the rising edge has settled
  always @(negedge clock) begin
    if (!rst && pixel !== pixPrev) begin
      check(runLen >= minRun, 1);
      if (runLen > maxRun) maxRun = runLen;
      runLen = 1;
    end else runLen++;
    pixPrev = pixel;
  end
  function automatic logic [33:0] mk(logic [1:0] s, logic [3:0] p, logic [3:0] l,
                                     logic [9:0] r);
    mk = {r, l, p, s, 14'($random(seed))};
  endfunction
  function automatic logic pick(int which);
    pick = (which == 0) ? pixel : (which == 1) ? load : tick;
  endfunction
  // High pulse length in cycles (tick: rise to next rise), plus pixel rises or reference falls inside it
  task automatic measure(input int which, output int cyc, output int ev);
    logic a, b, pP, rP;
    int guard;
    cyc = 0;
    ev = 0;
    guard = 0;
    a = pick(which);
    do begin
      @(posedge clock);
      #2;
      b = a;
      a = pick(which);
      guard++;
    end while (!(a && !b) && guard < 4000);
    pP = pixel;
    rP = refIn;
    do begin
      @(posedge clock);
      #2;
      b = a;
      a = pick(which);
      cyc++;
      if (which == 1 && pixel && !pP) ev++;
      if (which == 2 && !refIn && rP) ev++;
      pP = pixel;
      rP = refIn;
    end while (!((which == 2) ? (a && !b) : (!a && b)) && cyc < 4000);
  endtask
  initial begin
    int c, e, cur, rises;
    logic [3:0] p, l;
    logic [9:0] r;
    logic [33:0] w;
    logic [1:0] seen;
    logic h1, lp;
    rst = 1'b1;
    refIn = 1'b0;
    extIn = 1'b0;
    gate = 1'b1;
    pixPrev = 1'b0;
    repeat (3) @(posedge clock);
    #1 rst = 1'b0;
    check({pixel, load, tick, oeN, dOut}, 5'h02);
    measure(0, c, e);
    check(c, 16);
    measure(1, c, e);
    check(e, 4);
    measure(2, c, e);
    check(e, 20);
    cur = 16;
    for (int k = 0; k < 4; k++) begin
      p = (k == 1) ? 4'hf : (k == 2) ? 4'h0 : 4'($random(seed));
      l = (k == 3) ? 4'hf : 4'($random(seed));
      r = (k == 0) ? 10'h001 : 10'h001 + 10'($random(seed) & 7);
      w = mk(2'h1, p, l, r);
      minRun = (p + 1 < cur) ? p + 1 : cur;
      host.write_word(w);
      measure(0, c, e);
      check(c, p + 1);
      minRun = p + 1;
      cur = p + 1;
      if (k == 0) begin
        for (int i = 0; i < 34; i++) begin
          host.strobe(1'b1, 1'b1, 1'b0, 2, seen);
          check(seen, {1'b0, w[i]});
        end
      end
      measure(1, c, e);
      check(e, l + 1);
      measure(2, c, e);
      check(e, r);
    end
    maxRun = 0;
    host.write_word(w ^ 34'h0100000);
    repeat (100) @(posedge clock);
    check(maxRun <= cur, 1);
    @(posedge clock);
    #1 gate = 1'b0;
    rises = 0;
    lp = load;
    repeat (2000) begin
      @(posedge clock);
      #2;
      if (load && !lp) rises++;
      lp = load;
    end
    check(rises, 0);
    @(posedge clock);
    #1 gate = 1'b1;
    for (int s = 2; s < 4; s++) begin
      minRun = (cur < 3) ? cur : 3;
      host.write_word(mk(s[1:0], p, l, r));
      repeat (300) @(posedge clock);
      #2;
      h1 = extIn;
      // Pixel follows the external clock one cycle behind
      for (int i = 0; i < 32; i++) begin
        @(posedge clock);
        #2;
        check(pixel, h1);
        h1 = extIn;
      end
      cur = 3;
    end
    final_report();
  end
endmodule
